// File: rtl/mptv_unit.sv
`include "mptv_consts.svh"
module mptv_unit (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // core side
  mptv_if.unit cp,
  // unit state
  input wire logic translate_en,
  input wire logic [7:0] status_bits,
  input wire logic cur_level_we,
  input wire logic [7:0] cur_level_wdata,
  input wire logic lvl_ctrl_we,
  input wire logic [7:0] lvl_ctrl_wdata,
  output logic [7:0] current_level_register,
  output logic [7:0] level_control_register
);
  import mptv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // level registers: control holds count [7:4] and compare width [3:0]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      current_level_register <= `MPTV_CUR_LEVEL_RST;
    end else if (cur_level_we) begin
      current_level_register <= cur_level_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_control_register <= `MPTV_LVL_CTRL_RST;
    end else if (lvl_ctrl_we) begin
      level_control_register <= lvl_ctrl_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic ctrl_alterable(input logic [5:0] ea);
    logic [2:0] m;
    m = ea[5:3];
    ctrl_alterable = (m == `MPTV_EA_IND) || (m == `MPTV_EA_DISP) || (m == `MPTV_EA_IDX) ||
      ((m == `MPTV_EA_ABS) && (ea[2:1] == 2'b00));
  endfunction

  // upper compare bits of an 8-bit level over a given width
  function automatic logic [7:0] upper_bits(input logic [31:0] v, input logic [3:0] w);
    logic [3:0] wc;
    wc = (w > 4'h8) ? 4'h8 : w;
    upper_bits = (wc == 4'h0) ? 8'h00 : 8'(v[31:24] >> (4'h8 - wc));
  endfunction

  logic [15:0] op;
  logic [15:0] cw;
  logic [5:0] cond;
  logic cond_true;
  logic is_trap;
  logic is_val1;
  logic is_val2;
  logic is_probe;
  logic [2:0] opm;
  logic [7:0] src_lvl;
  logic [7:0] src_up;
  logic [7:0] dst_up;
  logic accept;

  assign op = cp.op_word;
  assign cw = cp.cmd_word;
  assign opm = op[2:0];
  assign is_trap = (op[15:6] == `MPTV_OP_GROUP_TR) && (op[5:3] == `MPTV_OP_TRAP_SEL);
  assign is_probe = (op[15:6] == `MPTV_OP_GROUP_PV) && (cw[15:13] == `MPTV_CW_PROBE_TAG);
  assign is_val1 = (op[15:6] == `MPTV_OP_GROUP_PV) && (cw == `MPTV_CW_VAL1);
  assign is_val2 = (op[15:6] == `MPTV_OP_GROUP_PV) && (cw[15:3] == `MPTV_CW_VAL2_TAG);
  assign cond = cw[5:0];
  // pairs test b,l,s,a,w,i,g,c; odd code tests clear
  assign cond_true = (cond[5:4] == 2'b00) &&
    (status_bits[3'(7 - cond[3:1])] ^ cond[0]);
  // form 1 uses the current level, form 2 the named core register
  assign src_lvl = is_val2 ? cp.areg_val[31:24] : current_level_register;
  assign src_up = upper_bits({src_lvl, 24'h0}, level_control_register[3:0]);
  assign dst_up = upper_bits(cp.ea_addr, level_control_register[3:0]);

  ////////////////////////////////////////////////////////////////////////////////
  // trap operand skip counter: words are swallowed without looking at them
  logic [1:0] skip_q;
  logic [1:0] skip_d;
  always_comb begin
    skip_d = skip_q;
    if (skip_q != 2'd0 && cp.operand_valid) begin
      skip_d = skip_q - 2'd1;
    end else if (accept && is_trap) begin
      case (opm)
        `MPTV_OPM_ONE: skip_d = 2'd1;
        `MPTV_OPM_TWO: skip_d = 2'd2;
        default: skip_d = 2'd0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      skip_q <= 2'd0;
    end else begin
      skip_q <= skip_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // answer held until the operands have been consumed
  mptv_dir_t pend_q;
  logic busy_q;
  // req stands through the answer cycle, so that cycle must not take it again
  assign accept = cp.req && !busy_q && !cp.resp;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      pend_q <= MPTV_DIR_NONE;
    end else if (accept && is_trap && skip_d != 2'd0) begin
      busy_q <= 1'b1;
      pend_q <= cond_true ? MPTV_DIR_TRAP : MPTV_DIR_DONE;
    end else if (busy_q && skip_d == 2'd0) begin
      busy_q <= 1'b0;
    end
  end
  assign cp.busy = busy_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cp.resp <= 1'b0;
      cp.dir <= MPTV_DIR_NONE;
      cp.operand_count <= 3'd0;
    end else begin
      cp.resp <= 1'b0;
      if (busy_q && skip_d == 2'd0) begin
        cp.resp <= 1'b1;
        cp.dir <= pend_q;
      end else if (accept) begin
        cp.resp <= (skip_d == 2'd0);
        cp.operand_count <= 3'd0;
        if (is_trap) begin
          if (opm != `MPTV_OPM_ONE && opm != `MPTV_OPM_TWO && opm != `MPTV_OPM_NONE) begin
            cp.dir <= MPTV_DIR_FLINE;
          end else begin
            cp.dir <= cond_true ? MPTV_DIR_TRAP : MPTV_DIR_DONE;
            cp.operand_count <= (opm == `MPTV_OPM_ONE) ? 3'd1 :
              (opm == `MPTV_OPM_TWO) ? 3'd2 : 3'd0;
          end
        end else if (is_probe) begin
          if (!translate_en) begin
            cp.dir <= MPTV_DIR_ILLEGAL;
          end else if (cw[12:10] == 3'd0 && cw[8:5] != 4'h0) begin
            cp.dir <= MPTV_DIR_FLINE;
          end else if (!ctrl_alterable(op[5:0])) begin
            cp.dir <= MPTV_DIR_FLINE;
          end else begin
            cp.dir <= MPTV_DIR_PROBE;
          end
        end else if ((is_val1 || is_val2) && ctrl_alterable(op[5:0])) begin
          if (level_control_register[7:4] == 4'h0 || src_up > dst_up) begin
            cp.dir <= MPTV_DIR_ACCESS;
          end else begin
            cp.dir <= MPTV_DIR_DONE;
          end
        end else begin
          cp.dir <= MPTV_DIR_FLINE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // probe request to the table walker
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cp.probe_level <= 3'd0;
      cp.probe_read <= 1'b0;
      cp.probe_ret_addr <= 1'b0;
      cp.probe_areg <= 3'd0;
      cp.probe_fc <= 4'h0;
      cp.probe_addr <= 32'h0;
    end else if (accept && is_probe) begin
      cp.probe_level <= cw[12:10];
      cp.probe_read <= cw[9];
      cp.probe_ret_addr <= cw[8];
      cp.probe_areg <= cw[7:5];
      cp.probe_fc <= cp.fc_val;
      cp.probe_addr <= cp.ea_addr;
    end
  end
endmodule

// File: rtl/mptv_consts.svh
`ifndef MPTV_CONSTS_SVH
`define MPTV_CONSTS_SVH
// opcode word fields
`define MPTV_OP_GROUP_HI 15
`define MPTV_OP_GROUP_LO 6
`define MPTV_OP_GROUP_PV 10'h3c0
`define MPTV_OP_GROUP_TR 10'h3c1
`define MPTV_OP_TRAP_SEL 3'h7
// command word fields
`define MPTV_CW_PROBE_TAG 3'h4
`define MPTV_CW_VAL1 16'h2800
`define MPTV_CW_VAL2_TAG 13'h0580
// trap_operand_form_field encodings
`define MPTV_OPM_ONE 3'h2
`define MPTV_OPM_TWO 3'h3
`define MPTV_OPM_NONE 3'h4
// effective address modes
`define MPTV_EA_IND 3'h2
`define MPTV_EA_DISP 3'h5
`define MPTV_EA_IDX 3'h6
`define MPTV_EA_ABS 3'h7
// reset values
`define MPTV_CUR_LEVEL_RST 8'h00
`define MPTV_LVL_CTRL_RST 8'h00
`endif

// File: rtl/mptv_pkg.sv
package mptv_pkg;
  typedef enum logic [2:0] {
    MPTV_DIR_NONE,
    MPTV_DIR_DONE,
    MPTV_DIR_TRAP,
    MPTV_DIR_FLINE,
    MPTV_DIR_ILLEGAL,
    MPTV_DIR_ACCESS,
    MPTV_DIR_PROBE
  } mptv_dir_t;
endpackage

// File: rtl/mptv_if.sv
interface mptv_if;
  import mptv_pkg::*;
  logic req;
  logic [15:0] op_word;
  logic [15:0] cmd_word;
  logic [31:0] ea_addr;
  logic [31:0] areg_val;
  logic [3:0] fc_val;
  logic [15:0] operand_word;
  logic operand_valid;
  logic busy;
  logic resp;
  mptv_dir_t dir;
  logic [2:0] operand_count;
  logic [2:0] probe_level;
  logic probe_read;
  logic probe_ret_addr;
  logic [2:0] probe_areg;
  logic [3:0] probe_fc;
  logic [31:0] probe_addr;
  modport unit(input req, op_word, cmd_word, ea_addr, areg_val, fc_val, operand_word,
    operand_valid, output busy, resp, dir, operand_count, probe_level, probe_read,
    probe_ret_addr, probe_areg, probe_fc, probe_addr);
  modport core(output req, op_word, cmd_word, ea_addr, areg_val, fc_val, operand_word,
    operand_valid, input busy, resp, dir, operand_count, probe_level, probe_read,
    probe_ret_addr, probe_areg, probe_fc, probe_addr);
endinterface

// File: rtl/mptv_core.sv
`include "mptv_consts.svh"
module mptv_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // unit side
  mptv_if.core cp,
  // instruction issue
  input wire logic issue,
  input wire logic [15:0] op_word,
  input wire logic [15:0] cmd_word,
  input wire logic [31:0] ea_addr,
  input wire logic [31:0] addr_regs [8],
  input wire logic [31:0] data_regs [8],
  input wire logic [2:0] source_function_code_reg,
  input wire logic [2:0] dfc,
  input wire logic [15:0] ext_words [2],
  // completion
  output logic done,
  output logic take_trap
);
  import mptv_pkg::*;

  typedef enum {MPTV_CS_IDLE, MPTV_CS_WAIT} mptv_core_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // function code source; reserved forms fall back to the sfc/dfc pair
  function automatic logic [3:0] fc_source(input logic [4:0] f, input logic [31:0] d,
    input logic [2:0] s, input logic [2:0] t);
    if (f[4]) begin
      fc_source = f[3:0];
    end else if (f[3]) begin
      fc_source = d[3:0];
    end else if (f[0]) begin
      fc_source = {1'b0, t};
    end else begin
      fc_source = {1'b0, s};
    end
  endfunction

  mptv_core_state_t state_q;
  logic start;
  logic is_trap;
  logic [2:0] opm;
  logic [1:0] left_q;
  logic word_sel_q;

  assign start = (state_q == MPTV_CS_IDLE) && issue;
  assign opm = op_word[2:0];
  assign is_trap = (op_word[15:6] == `MPTV_OP_GROUP_TR) &&
    (op_word[5:3] == `MPTV_OP_TRAP_SEL);

  ////////////////////////////////////////////////////////////////////////////////
  // request stands until the answer; one idle cycle follows so it is not taken twice
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= MPTV_CS_IDLE;
      cp.req <= 1'b0;
    end else begin
      case (state_q)
        MPTV_CS_IDLE: begin
          if (issue) begin
            state_q <= MPTV_CS_WAIT;
            cp.req <= 1'b1;
          end
        end
        MPTV_CS_WAIT: begin
          if (cp.resp) begin
            state_q <= MPTV_CS_IDLE;
            cp.req <= 1'b0;
          end
        end
        default: begin
          state_q <= MPTV_CS_IDLE;
          cp.req <= 1'b0;
        end
      endcase
    end
  end

  // words are caught at issue and held, so the unit may read them at any point
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cp.op_word <= 16'h0000;
      cp.cmd_word <= 16'h0000;
      cp.ea_addr <= 32'h00000000;
      cp.areg_val <= 32'h00000000;
      cp.fc_val <= 4'h0;
    end else if (start) begin
      cp.op_word <= op_word;
      cp.cmd_word <= cmd_word;
      cp.ea_addr <= ea_addr;
      cp.areg_val <= addr_regs[cmd_word[2:0]];
      cp.fc_val <= fc_source(cmd_word[4:0], data_regs[cmd_word[2:0]], source_function_code_reg, dfc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trailing words go out one a cycle while the unit is busy swallowing them
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      left_q <= 2'd0;
      word_sel_q <= 1'b0;
      cp.operand_valid <= 1'b0;
      cp.operand_word <= 16'h0000;
    end else if (start) begin
      word_sel_q <= 1'b0;
      cp.operand_valid <= 1'b0;
      if (is_trap && opm == `MPTV_OPM_ONE) begin
        left_q <= 2'd1;
      end else if (is_trap && opm == `MPTV_OPM_TWO) begin
        left_q <= 2'd2;
      end else begin
        left_q <= 2'd0;
      end
    end else if (cp.busy && left_q != 2'd0) begin
      cp.operand_valid <= 1'b1;
      cp.operand_word <= ext_words[word_sel_q];
      word_sel_q <= 1'b1;
      left_q <= left_q - 2'd1;
    end else begin
      cp.operand_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trap decision stands until the next answer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done <= 1'b0;
      take_trap <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state_q == MPTV_CS_WAIT && cp.resp) begin
        done <= 1'b1;
        take_trap <= (cp.dir == MPTV_DIR_TRAP);
      end
    end
  end
endmodule

// File: test/mptv_checker.sv
`include "mptv_consts.svh"
module mptv_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link signals
  input wire logic req,
  input wire logic resp,
  input wire logic [15:0] op_word,
  input wire logic [15:0] cmd_word,
  input wire logic [31:0] ea_addr,
  input wire mptv_pkg::mptv_dir_t dir,
  input wire logic [2:0] operand_count,
  input wire logic [2:0] probe_level,
  input wire logic probe_read,
  input wire logic probe_ret_addr,
  input wire logic [2:0] probe_areg,
  input wire logic [3:0] probe_fc,
  input wire logic [31:0] probe_addr
);
  import mptv_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // the core holds its request words until the answer, so they qualify it
  logic pr, pc, tr, ok;
  assign pr = resp && dir == MPTV_DIR_PROBE;
  assign pc = op_word[15:6] == `MPTV_OP_GROUP_PV && cmd_word[15:13] == `MPTV_CW_PROBE_TAG;
  assign tr = op_word[15:6] == `MPTV_OP_GROUP_TR && op_word[5:3] == `MPTV_OP_TRAP_SEL;
  assign ok = op_word[2:0] inside {`MPTV_OPM_ONE, `MPTV_OPM_TWO, `MPTV_OPM_NONE};
  sequence s_answer;
    ##[1:64] resp;
  endsequence
  ////////////////////////////////////////
  chk_answer_bound: assert property ($rose(req) |-> s_answer)
    else $error("no answer");
  chk_probe_level: assert property (pr |-> probe_level == cmd_word[12:10])
    else $error("probe level");
  chk_probe_rw: assert property (pr |-> probe_read == cmd_word[9])
    else $error("probe rw");
  chk_probe_target: assert property (
    pr |-> {probe_ret_addr, probe_areg} == cmd_word[8:5]) else $error("probe target");
  chk_probe_addr: assert property (pr |-> probe_addr == ea_addr)
    else $error("probe addr");
  chk_fc_immediate: assert property (
    pr && cmd_word[4] |-> probe_fc == cmd_word[3:0]) else $error("probe fc");
  chk_zero_level: assert property (
    resp && pc && cmd_word[12:5] inside {[8'h01:8'h0f]} |-> dir == MPTV_DIR_FLINE)
    else $error("zero level");
  chk_bad_opmode: assert property (
    resp && tr && !ok |-> dir == MPTV_DIR_FLINE) else $error("bad opmode");
  chk_trap_answer: assert property (
    resp && tr && ok |-> dir inside {MPTV_DIR_DONE, MPTV_DIR_TRAP})
    else $error("trap answer");
  chk_operand_count: assert property (
    resp && tr && ok |-> operand_count == ((op_word[2:0] == `MPTV_OPM_ONE) ? 3'd1 :
      (op_word[2:0] == `MPTV_OPM_TWO) ? 3'd2 : 3'd0)) else $error("operand count");
endmodule

// File: test/tb.sv
`include "mptv_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mptv_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, issue = 1'b0, ten = 1'b1, cwe = 1'b0, lwe = 1'b0;
  logic take, done;
  logic [7:0] stat = 8'h00, cwd = 8'h00, lwd = 8'h00, cur_q, lvl_q;
  logic [15:0] op = 16'h0000, cmd = 16'h0000;
  logic [31:0] ea = 32'h0;
  logic [31:0] ar [8] = '{default: 32'h0};
  logic [31:0] dr [8] = '{default: 32'h0000000b};
  logic [15:0] ext [2] = '{default: 16'h0};
  logic [3:0] fc_q;
  mptv_dir_t dir_q;
  logic [2:0] opm [3] = '{`MPTV_OPM_ONE, `MPTV_OPM_TWO, `MPTV_OPM_NONE};
  // probe rows: command word, then the function code it must yield
  logic [19:0] prow [4] = '{{3'h4, 3'h3, 1'b1, 4'ha, 5'h15, 4'h5},
    {3'h4, 3'h0, 1'b0, 4'h0, 5'h0b, 4'hb}, {3'h4, 3'h1, 1'b0, 4'h0, 5'h00, 4'h3},
    {3'h4, 3'h7, 1'b1, 4'h0, 5'h01, 4'h5}};
  int num_errors = 0, num_checks = 0;
  always #2 clk = ~clk;
  ////////////////////////////////////////
  mptv_if cp_if ();
  mptv_unit mptv_unit_inst (.clk(clk), .reset_n(reset_n), .cp(cp_if), .translate_en(ten),
    .status_bits(stat), .cur_level_we(cwe), .cur_level_wdata(cwd), .lvl_ctrl_we(lwe),
    .lvl_ctrl_wdata(lwd), .current_level_register(cur_q), .level_control_register(lvl_q));
  mptv_core mptv_core_inst (.clk(clk), .reset_n(reset_n), .cp(cp_if), .issue(issue),
    .op_word(op), .cmd_word(cmd), .ea_addr(ea), .addr_regs(ar), .data_regs(dr), .source_function_code_reg(3'h3),
    .dfc(3'h5), .ext_words(ext), .done(done), .take_trap(take));
  mptv_checker mptv_checker_inst (.clk(clk), .reset_n(reset_n), .req(cp_if.req),
    .resp(cp_if.resp), .op_word(cp_if.op_word), .cmd_word(cp_if.cmd_word),
    .ea_addr(cp_if.ea_addr), .dir(cp_if.dir), .operand_count(cp_if.operand_count),
    .probe_level(cp_if.probe_level),
    .probe_read(cp_if.probe_read), .probe_ret_addr(cp_if.probe_ret_addr),
    .probe_areg(cp_if.probe_areg), .probe_fc(cp_if.probe_fc), .probe_addr(cp_if.probe_addr));
  always @(posedge clk) if (cp_if.resp) begin
    dir_q <= cp_if.dir;
    fc_q <= cp_if.probe_fc;
  end
  ////////////////////////////////////////
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  // fields stay up until the next issue so the core may sample them late
  task automatic go(input logic [15:0] o, c, input logic [31:0] a, input mptv_dir_t d);
    int n;
    @(posedge clk) #1;
    op = o;
    cmd = c;
    ea = a;
    issue = 1'b1;
    @(posedge clk) #1;
    issue = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      if (++n > 200) begin
        num_errors++;
        finish_test();
      end
      @(posedge clk) #1;
    end
    chk("dir", d, dir_q);
  endtask
  task automatic wr(input logic [7:0] c, l);
    @(posedge clk) #1;
    {cwe, lwe, cwd, lwd} = {2'b11, c, l};
    @(posedge clk) #1;
    {cwe, lwe} = 2'b00;
    chk("cur", c, cur_q);
    chk("lvl", l, lvl_q);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("cur", `MPTV_CUR_LEVEL_RST, cur_q);
    chk("lvl", `MPTV_LVL_CTRL_RST, lvl_q);
    for (int i = 0; i < 4; i++) begin
      go(16'hf010, prow[i][19:4], 32'h12345678, MPTV_DIR_PROBE);
      chk("fc", prow[i][3:0], fc_q);
    end
    for (int i = 0; i < 32; i++) begin
      logic t;
      // only the selected status bit carries i[4]; the rest show the opposite
      t = i[0] ^ i[4];
      stat = i[4] ? (8'h80 >> i[3:1]) : ~(8'h80 >> i[3:1]);
      ext[0] = i[15:0] ^ 16'ha5a5;
      go({13'h1e0f, opm[i % 3]}, {10'h0, 2'b00, i[3:0]}, 32'h0,
        t ? MPTV_DIR_TRAP : MPTV_DIR_DONE);
      chk("take", t, take);
    end
    go(16'hf07d, 16'h0000, 32'h0, MPTV_DIR_FLINE);
    go(16'hf010, 16'h8100, 32'h0, MPTV_DIR_FLINE);
    go(16'hf000, 16'h8c15, 32'h0, MPTV_DIR_FLINE);
    ten = 1'b0;
    go(16'hf010, 16'h8c15, 32'h0, MPTV_DIR_ILLEGAL);
    ten = 1'b1;
    go(16'hf010, 16'h2800, 32'hffffffff, MPTV_DIR_ACCESS);
    wr(8'h00, 8'hff);
    go(16'hf010, 16'h2800, 32'hffffffff, MPTV_DIR_DONE);
    wr(8'hff, 8'hff);
    go(16'hf010, 16'h2800, 32'h0, MPTV_DIR_ACCESS);
    go(16'hf010, 16'h2c05, 32'h0, MPTV_DIR_DONE);
    ar[5] = 32'hffffffff;
    go(16'hf010, 16'h2c05, 32'h0, MPTV_DIR_ACCESS);
    wr(8'hff, 8'hf4);
    ar[5] = 32'h0f000000;
    go(16'hf010, 16'h2c05, 32'h0, MPTV_DIR_DONE);
    finish_test();
  end
endmodule
